// *** tvvt_pkg.sv ***
// Shared constants and types for the TV-out vertical timing block.
// Assumes one clock domain and the CRT controller index/data port outside.
package tvvt_pkg;

  // Index/data pair inside the CRT controller data port
  localparam logic [7:0] TVVT_PORT_INDEX = 8'hE0;
  localparam logic [7:0] TVVT_PORT_DATA = 8'hE1;

  // TV-out register indexes
  localparam logic [7:0] TVVT_IDX_CTRL = 8'h00;
  localparam logic [7:0] TVVT_IDX_SCALE = 8'h01;
  localparam logic [7:0] TVVT_IDX_STD_PH_HI = 8'h02;
  localparam logic [7:0] TVVT_IDX_PH_MID = 8'h03;
  localparam logic [7:0] TVVT_IDX_PH_LO = 8'h04;
  localparam logic [7:0] TVVT_IDX_ACT_SO = 8'h05;
  localparam logic [7:0] TVVT_IDX_ACT_SE = 8'h06;
  localparam logic [7:0] TVVT_IDX_ACT_EO = 8'h07;
  localparam logic [7:0] TVVT_IDX_ACT_EE = 8'h08;
  localparam logic [7:0] TVVT_IDX_ACT_OVF = 8'h09;
  localparam logic [7:0] TVVT_IDX_VS_O = 8'h0A;
  localparam logic [7:0] TVVT_IDX_EQ1_O = 8'h0B;
  localparam logic [7:0] TVVT_IDX_EQ2_O = 8'h0C;
  localparam logic [7:0] TVVT_IDX_VS_E = 8'h0D;
  localparam logic [7:0] TVVT_IDX_SYNC_OVF = 8'h0E;
  localparam logic [7:0] TVVT_IDX_EQ1_E = 8'h0F;
  localparam logic [7:0] TVVT_IDX_EQ2_E = 8'h10;
  localparam logic [7:0] TVVT_IDX_PRESET = 8'h11;
  localparam logic [7:0] TVVT_IDX_LBUF = 8'h12;
  localparam logic [7:0] TVVT_IDX_OVF3 = 8'h13;
  localparam int TVVT_NUM_REGS = 20;
  localparam logic [7:0] TVVT_RESET_VAL = 8'h00;

  // Control register field positions, plus the PAL bit of the standard/phase high byte
  localparam int TVVT_FILT_MSB = 7;
  localparam int TVVT_FILT_LSB = 5;
  localparam int TVVT_BIT_COMP_OFF = 4;
  localparam int TVVT_BIT_SVID_OFF = 3;
  localparam int TVVT_BIT_TV_ON = 2;
  localparam int TVVT_BIT_SHRINK = 1;
  localparam int TVVT_BIT_INTERLACE = 0;
  localparam int TVVT_BIT_PAL = 7;

  // Two-bit overflow pair positions
  localparam logic [1:0] TVVT_PAIR0 = 2'h0;
  localparam logic [1:0] TVVT_PAIR1 = 2'h1;
  localparam logic [1:0] TVVT_PAIR2 = 2'h2;
  localparam logic [1:0] TVVT_PAIR3 = 2'h3;

  // Data port access from the host side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] port_idx;
    logic [7:0] wdata;
  } tvvt_bus_s;

  // Vertical timing windows
  typedef struct packed {
    logic odd_field;
    logic equalize;
    logic vsync;
    logic active;
  } tvvt_vtim_s;

  // Anti-flicker filter choice
  typedef enum logic [2:0] {
    TVVT_FILT_NONE = 3'h0,
    TVVT_FILT_LIGHT = 3'h1,
    TVVT_FILT_MEDIAN = 3'h2,
    TVVT_FILT_STRONG = 3'h3,
    TVVT_FILT_ADAPT = 3'h4
  } tvvt_filter_e;

  // Vertical interval phases, one-hot
  typedef enum logic [3:0] {
    TVVT_ST_EQ1 = 4'h1,
    TVVT_ST_VSYNC = 4'h2,
    TVVT_ST_EQ2 = 4'h4,
    TVVT_ST_BODY = 4'h8
  } tvvt_vstate_e;

endpackage

// *** tvvt_subcarrier.sv ***
// Subcarrier phase accumulator for the TV encoder.
// Assumes the step word comes from registers on the same clock.
`timescale 1ns/1ps
module tvvt_subcarrier (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [22:0] step,
  // Phase out
  output logic [22:0] phase
);

  // Wraps modulo 2^23; held at zero while TV mode is off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= 23'h000000;
    end else if (!run) begin
      phase <= 23'h000000;
    end else begin
      phase <= phase + step;
    end
  end

  property p_phase_step;
    @(posedge clk) disable iff (!rst_n)
      run && $past(run) && $past(rst_n) |-> phase == 23'($past(phase) + $past(step));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance by step");

endmodule

// *** tvvt_tv_model.sv ***
// Receiver-side model: tallies sync and picture lines of each field.
// Assumes line and field strobes arrive on the encoder clock.
`timescale 1ns/1ps
module tvvt_tv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raster strobes and windows
  input wire logic line_start,
  input wire logic field_start,
  input wire tvvt_pkg::tvvt_vtim_s vtim,
  // Tallies for the field so far
  output logic [9:0] sync_lines,
  output logic [9:0] pic_lines
);
  // Windows sampled as each line closes; a new field clears the tallies
  always_ff @(posedge clk) begin
    if (!rst_n || field_start) begin
      sync_lines <= 10'h000;
      pic_lines <= 10'h000;
    end else if (line_start) begin
      sync_lines <= sync_lines + {9'h000, vtim.vsync};
      pic_lines <= pic_lines + {9'h000, vtim.active};
    end
  end
endmodule

// *** tvvt_vertical_timing.sv ***
// TV-out control registers and vertical timing generator.
// Assumes host accesses arrive as single-cycle strobes on clk, and line
// and field strobes come from the horizontal timing on the same clock.
`timescale 1ns/1ps
module tvvt_vertical_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // CRT controller data port
  input wire tvvt_pkg::tvvt_bus_s bus,
  output logic [7:0] rdata,
  output logic rdata_valid,
  // Strobes from horizontal timing
  input wire logic line_start,
  input wire logic field_start,
  // Encoder controls
  output logic tv_mode_on,
  output logic composite_on,
  output logic svideo_on,
  output logic pal_select,
  output tvvt_pkg::tvvt_filter_e filter_mode,
  output logic [7:0] vertical_compress_factor,
  output logic line_skip,
  // Vertical timing
  output tvvt_pkg::tvvt_vtim_s vtim,
  output logic [9:0] line_count,
  output logic [22:0] subcarrier_phase
);

  logic [7:0] tv_reg [0:tvvt_pkg::TVVT_NUM_REGS-1];
  logic [7:0] reg_index;
  logic [7:0] sel_byte;
  logic sel_mapped;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic [7:0] ctrl;
  logic interlace_select;
  logic shrink_on;
  logic [22:0] subcarrier_phase_step;
  logic [9:0] active_start_line_odd;
  logic [9:0] active_start_line_even;
  logic [9:0] active_end_line_odd;
  logic [9:0] active_end_line_even;
  logic [9:0] vertical_sync_end_odd;
  logic [9:0] first_equalizer_end_odd;
  logic [9:0] second_equalizer_end_odd;
  logic [9:0] vertical_sync_end_even;
  logic [9:0] first_equalizer_end_even;
  logic [9:0] second_equalizer_end_even;
  logic [9:0] line_counter_preset;
  logic [9:0] cur_act_start;
  logic [9:0] cur_act_end;
  logic [9:0] cur_vs_end;
  logic [9:0] cur_eq1_end;
  logic [9:0] cur_eq2_end;
  logic [7:0] shrink_acc;
  logic [8:0] shrink_sum;
  logic odd_field;
  tvvt_pkg::tvvt_vstate_e vstate;
  tvvt_pkg::tvvt_vstate_e next_vstate;

  // Joins a low byte with one two-bit pair of an overflow byte
  function automatic logic [9:0] join10(input logic [7:0] low, input logic [7:0] ovf,
                                         input logic [1:0] pair);
    logic [1:0] hi;
    hi = ovf[{pair, 1'b0} +: 2];
    return {hi, low};
  endfunction

  // Anti-flicker decode, top bit set means adaptive
  function automatic tvvt_pkg::tvvt_filter_e decode_filter(input logic [2:0] code);
    tvvt_pkg::tvvt_filter_e f;
    case (code)
      3'h0: f = tvvt_pkg::TVVT_FILT_NONE;
      3'h1: f = tvvt_pkg::TVVT_FILT_LIGHT;
      3'h2: f = tvvt_pkg::TVVT_FILT_MEDIAN;
      3'h3: f = tvvt_pkg::TVVT_FILT_STRONG;
      default: f = tvvt_pkg::TVVT_FILT_ADAPT;
    endcase
    return f;
  endfunction

  // Port decode
  assign idx_wr = bus.wr && bus.port_idx == tvvt_pkg::TVVT_PORT_INDEX;
  assign dat_wr = bus.wr && bus.port_idx == tvvt_pkg::TVVT_PORT_DATA;
  assign dat_rd = bus.rd && bus.port_idx == tvvt_pkg::TVVT_PORT_DATA;
  assign sel_mapped = reg_index < 8'(tvvt_pkg::TVVT_NUM_REGS);

  // Selected byte; indexes past the table read as zero
  always_comb begin
    sel_byte = 8'h00;
    if (sel_mapped) begin
      sel_byte = tv_reg[reg_index[4:0]];
    end
  end

  // Index register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_index <= tvvt_pkg::TVVT_RESET_VAL;
    end else if (idx_wr) begin
      reg_index <= bus.wdata;
    end
  end

  // Register table; writes to unmapped indexes are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < tvvt_pkg::TVVT_NUM_REGS; i++) begin
        tv_reg[i] <= tvvt_pkg::TVVT_RESET_VAL;
      end
    end else if (dat_wr && sel_mapped) begin
      tv_reg[reg_index[4:0]] <= bus.wdata;
    end
  end

  // Read data, registered so it is stable for the host one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= bus.rd;
      if (dat_rd) begin
        rdata <= sel_byte;
      end else if (bus.rd && bus.port_idx == tvvt_pkg::TVVT_PORT_INDEX) begin
        rdata <= reg_index;
      end else if (bus.rd) begin
        rdata <= 8'h00;
      end
    end
  end

  // Control decode
  assign ctrl = tv_reg[tvvt_pkg::TVVT_IDX_CTRL[4:0]];
  assign filter_mode = decode_filter(ctrl[tvvt_pkg::TVVT_FILT_MSB:tvvt_pkg::TVVT_FILT_LSB]);
  assign tv_mode_on = ctrl[tvvt_pkg::TVVT_BIT_TV_ON];
  assign composite_on = !ctrl[tvvt_pkg::TVVT_BIT_COMP_OFF];
  assign svideo_on = !ctrl[tvvt_pkg::TVVT_BIT_SVID_OFF];
  assign shrink_on = ctrl[tvvt_pkg::TVVT_BIT_SHRINK];
  assign interlace_select = ctrl[tvvt_pkg::TVVT_BIT_INTERLACE];
  assign vertical_compress_factor = tv_reg[tvvt_pkg::TVVT_IDX_SCALE[4:0]];
  assign pal_select = tv_reg[tvvt_pkg::TVVT_IDX_STD_PH_HI[4:0]][tvvt_pkg::TVVT_BIT_PAL];

  // Subcarrier step assembled from three bytes
  assign subcarrier_phase_step = {tv_reg[tvvt_pkg::TVVT_IDX_STD_PH_HI[4:0]][6:0],
                                  tv_reg[tvvt_pkg::TVVT_IDX_PH_MID[4:0]],
                                  tv_reg[tvvt_pkg::TVVT_IDX_PH_LO[4:0]]};

  // Ten-bit line boundaries
  assign active_start_line_odd = join10(tv_reg[tvvt_pkg::TVVT_IDX_ACT_SO[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_ACT_OVF[4:0]], tvvt_pkg::TVVT_PAIR0);
  assign active_start_line_even = join10(tv_reg[tvvt_pkg::TVVT_IDX_ACT_SE[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_ACT_OVF[4:0]], tvvt_pkg::TVVT_PAIR1);
  assign active_end_line_odd = join10(tv_reg[tvvt_pkg::TVVT_IDX_ACT_EO[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_ACT_OVF[4:0]], tvvt_pkg::TVVT_PAIR2);
  assign active_end_line_even = join10(tv_reg[tvvt_pkg::TVVT_IDX_ACT_EE[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_ACT_OVF[4:0]], tvvt_pkg::TVVT_PAIR3);
  assign vertical_sync_end_odd = join10(tv_reg[tvvt_pkg::TVVT_IDX_VS_O[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_SYNC_OVF[4:0]], tvvt_pkg::TVVT_PAIR0);
  assign first_equalizer_end_odd = join10(tv_reg[tvvt_pkg::TVVT_IDX_EQ1_O[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_SYNC_OVF[4:0]], tvvt_pkg::TVVT_PAIR1);
  assign second_equalizer_end_odd = join10(tv_reg[tvvt_pkg::TVVT_IDX_EQ2_O[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_SYNC_OVF[4:0]], tvvt_pkg::TVVT_PAIR2);
  assign vertical_sync_end_even = join10(tv_reg[tvvt_pkg::TVVT_IDX_VS_E[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_SYNC_OVF[4:0]], tvvt_pkg::TVVT_PAIR3);
  assign first_equalizer_end_even = join10(tv_reg[tvvt_pkg::TVVT_IDX_EQ1_E[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_OVF3[4:0]], tvvt_pkg::TVVT_PAIR0);
  assign second_equalizer_end_even = join10(tv_reg[tvvt_pkg::TVVT_IDX_EQ2_E[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_OVF3[4:0]], tvvt_pkg::TVVT_PAIR1);
  assign line_counter_preset = join10(tv_reg[tvvt_pkg::TVVT_IDX_PRESET[4:0]],
    tv_reg[tvvt_pkg::TVVT_IDX_OVF3[4:0]], tvvt_pkg::TVVT_PAIR2);

  // Bounds of the field now being scanned
  always_comb begin
    if (odd_field) begin
      cur_act_start = active_start_line_odd;
      cur_act_end = active_end_line_odd;
      cur_vs_end = vertical_sync_end_odd;
      cur_eq1_end = first_equalizer_end_odd;
      cur_eq2_end = second_equalizer_end_odd;
    end else begin
      cur_act_start = active_start_line_even;
      cur_act_end = active_end_line_even;
      cur_vs_end = vertical_sync_end_even;
      cur_eq1_end = first_equalizer_end_even;
      cur_eq2_end = second_equalizer_end_even;
    end
  end

  // Field parity; non-interlaced always stays on the odd field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      odd_field <= 1'b1;
    end else if (field_start) begin
      odd_field <= interlace_select ? !odd_field : 1'b1;
    end
  end

  // Line counter; a field start wins over a line start in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_count <= 10'h000;
    end else if (field_start) begin
      line_count <= line_counter_preset;
    end else if (line_start) begin
      line_count <= line_count + 10'h001;
    end
  end

  // Vertical interval sequence; an end line of zero cuts that phase to one clock
  always_comb begin
    next_vstate = vstate;
    case (vstate)
      tvvt_pkg::TVVT_ST_EQ1: begin
        if (line_count >= cur_eq1_end) next_vstate = tvvt_pkg::TVVT_ST_VSYNC;
      end
      tvvt_pkg::TVVT_ST_VSYNC: begin
        if (line_count >= cur_vs_end) next_vstate = tvvt_pkg::TVVT_ST_EQ2;
      end
      tvvt_pkg::TVVT_ST_EQ2: begin
        if (line_count >= cur_eq2_end) next_vstate = tvvt_pkg::TVVT_ST_BODY;
      end
      tvvt_pkg::TVVT_ST_BODY: begin
        next_vstate = tvvt_pkg::TVVT_ST_BODY;
      end
      default: begin
        next_vstate = tvvt_pkg::TVVT_ST_BODY;
      end
    endcase
    if (field_start) begin
      next_vstate = tvvt_pkg::TVVT_ST_EQ1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vstate <= tvvt_pkg::TVVT_ST_BODY;
    end else begin
      vstate <= next_vstate;
    end
  end

  // Timing windows; equalize, vsync and active forced low while TV mode is off, odd_field always follows the parity
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vtim <= '0;
    end else begin
      vtim.odd_field <= odd_field;
      vtim.equalize <= tv_mode_on && (next_vstate == tvvt_pkg::TVVT_ST_EQ1 ||
                                      next_vstate == tvvt_pkg::TVVT_ST_EQ2);
      vtim.vsync <= tv_mode_on && next_vstate == tvvt_pkg::TVVT_ST_VSYNC;
      vtim.active <= tv_mode_on && next_vstate == tvvt_pkg::TVVT_ST_BODY &&
                     line_count >= cur_act_start && line_count < cur_act_end;
    end
  end

  // Line compression: a carry out of the scale accumulator drops a line.
  // Cheap but uneven; a filter would spread the loss better.
  assign shrink_sum = {1'b0, shrink_acc} + {1'b0, vertical_compress_factor};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shrink_acc <= 8'h00;
      line_skip <= 1'b0;
    end else if (!shrink_on || field_start) begin
      shrink_acc <= 8'h00;
      line_skip <= 1'b0;
    end else if (line_start) begin
      shrink_acc <= shrink_sum[7:0];
      line_skip <= shrink_sum[8];
    end
  end

  // Subcarrier phase generator
  tvvt_subcarrier u_subcarrier (
    .clk(clk),
    .rst_n(rst_n),
    .run(tv_mode_on),
    .step(subcarrier_phase_step),
    .phase(subcarrier_phase)
  );

  property p_index_write;
    @(posedge clk) disable iff (!rst_n)
      idx_wr |=> reg_index == $past(bus.wdata);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index not captured");

  property p_data_path;
    @(posedge clk) disable iff (!rst_n)
      dat_wr && sel_mapped ##1 dat_rd && $stable(reg_index) |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_data_path: assert property (p_data_path) else $error("data port readback wrong");

  property p_filter;
    @(posedge clk) disable iff (!rst_n)
      dat_wr && reg_index == tvvt_pkg::TVVT_IDX_CTRL && bus.wdata[7] |=>
        filter_mode == tvvt_pkg::TVVT_FILT_ADAPT;
  endproperty
  a_filter: assert property (p_filter) else $error("adaptive filter not chosen");

  property p_composite;
    @(posedge clk) disable iff (!rst_n)
      dat_wr && reg_index == tvvt_pkg::TVVT_IDX_CTRL |=> composite_on == !$past(bus.wdata[4]);
  endproperty
  a_composite: assert property (p_composite) else $error("composite enable wrong");

  property p_svideo;
    @(posedge clk) disable iff (!rst_n)
      dat_wr && reg_index == tvvt_pkg::TVVT_IDX_CTRL |=> svideo_on == !$past(bus.wdata[3]);
  endproperty
  a_svideo: assert property (p_svideo) else $error("S-Video enable wrong");

  property p_tv_off_quiet;
    @(posedge clk) disable iff (!rst_n)
      !tv_mode_on ##1 !tv_mode_on |-> !vtim.vsync && !vtim.active && !vtim.equalize;
  endproperty
  a_tv_off_quiet: assert property (p_tv_off_quiet) else $error("timing active with TV off");

  property p_no_shrink;
    @(posedge clk) disable iff (!rst_n)
      !shrink_on |=> !line_skip;
  endproperty
  a_no_shrink: assert property (p_no_shrink) else $error("line dropped without shrink");

  property p_progressive_odd;
    @(posedge clk) disable iff (!rst_n)
      field_start && !interlace_select |=> odd_field ##1 vtim.odd_field;
  endproperty
  a_progressive_odd: assert property (p_progressive_odd) else $error("even field in progressive");

  property p_preset;
    @(posedge clk) disable iff (!rst_n)
      field_start |=> line_count == $past(line_counter_preset) && vstate == tvvt_pkg::TVVT_ST_EQ1;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  property p_reset_state;
    @(posedge clk) !rst_n |=> reg_index == 8'h00 && !tv_mode_on && composite_on && svideo_on;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  c_pal: cover property (@(posedge clk) disable iff (!rst_n) pal_select && tv_mode_on);
  c_vsync: cover property (@(posedge clk) disable iff (!rst_n) $rose(vtim.vsync));
  c_active: cover property (@(posedge clk) disable iff (!rst_n) $rose(vtim.active));
  c_even: cover property (@(posedge clk) disable iff (!rst_n) interlace_select && !odd_field);

endmodule

// *** tvvt_vertical_timing_tb.sv ***
// Self-checking bench for the TV-out control and vertical timing block.
// Assumes the bench plays host port, horizontal timing and receiver.
`timescale 1ns/1ps
module tvvt_vertical_timing_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tvvt_pkg::tvvt_bus_s bus = '0;
  logic line_start = 1'b0;
  logic field_start = 1'b0;
  logic [7:0] rdata;
  logic rdata_valid;
  logic tv_mode_on;
  logic composite_on;
  logic svideo_on;
  logic pal_select;
  tvvt_pkg::tvvt_filter_e filter_mode;
  logic [7:0] vertical_compress_factor;
  logic line_skip;
  tvvt_pkg::tvvt_vtim_s vtim;
  logic [9:0] line_count;
  logic [22:0] subcarrier_phase;
  logic [9:0] sync_lines;
  logic [9:0] pic_lines;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  // Timing bounds for both fields, index in the high byte
  logic [15:0] tbl [14] = '{16'h050C, 16'h060B, 16'h0710, 16'h080E, 16'h0955, 16'h0A08, 16'h0B05,
    16'h0C0A, 16'h0D06, 16'h0E55, 16'h0F04, 16'h1009, 16'h1102, 16'h1315};

  tvvt_vertical_timing dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .rdata_valid(rdata_valid), .line_start(line_start), .field_start(field_start),
    .tv_mode_on(tv_mode_on), .composite_on(composite_on), .svideo_on(svideo_on),
    .pal_select(pal_select), .filter_mode(filter_mode),
    .vertical_compress_factor(vertical_compress_factor), .line_skip(line_skip), .vtim(vtim),
    .line_count(line_count), .subcarrier_phase(subcarrier_phase));

  tvvt_tv_model tv_u (.clk(clk), .rst_n(rst_n), .line_start(line_start),
    .field_start(field_start), .vtim(vtim), .sync_lines(sync_lines), .pic_lines(pic_lines));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Hang guard, far above the roughly 600 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] port, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.port_idx = port;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  // Answer lands one edge after the read is taken
  task automatic rd(input logic [7:0] port, input logic [7:0] exp);
    @(negedge clk);
    bus.rd = 1'b1;
    bus.port_idx = port;
    @(negedge clk);
    chk("rdata_valid", 23'h1, 23'(rdata_valid));
    chk("rdata", 23'(exp), 23'(rdata));
    bus.rd = 1'b0;
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    wr(tvvt_pkg::TVVT_PORT_INDEX, idx);
    wr(tvvt_pkg::TVVT_PORT_DATA, d);
  endtask

  task automatic pulse(input logic fs);
    @(negedge clk);
    if (fs) field_start = 1'b1;
    else line_start = 1'b1;
    @(negedge clk);
    field_start = 1'b0;
    line_start = 1'b0;
  endtask

  task automatic t_reset();
    chk("tv_mode_on", 23'h0, 23'(tv_mode_on));
    chk("outputs on", 23'h3, 23'({composite_on, svideo_on}));
    chk("vtim", 23'h0, 23'(vtim));
    rd(tvvt_pkg::TVVT_PORT_INDEX, 8'h00);
    for (int i = 0; i < 20; i++) begin
      wr(tvvt_pkg::TVVT_PORT_INDEX, 8'(i));
      rd(tvvt_pkg::TVVT_PORT_DATA, 8'h00);
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 20; i++) wreg(8'(i), {4'(i), ~4'(i)});
    for (int i = 0; i < 20; i++) begin
      wr(tvvt_pkg::TVVT_PORT_INDEX, 8'(i));
      rd(tvvt_pkg::TVVT_PORT_INDEX, 8'(i));
      rd(tvvt_pkg::TVVT_PORT_DATA, {4'(i), ~4'(i)});
    end
    // Data write then data read on the very next edge
    wr(tvvt_pkg::TVVT_PORT_INDEX, tvvt_pkg::TVVT_IDX_SCALE);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.port_idx = tvvt_pkg::TVVT_PORT_DATA;
    bus.wdata = 8'h3C;
    @(negedge clk);
    bus.wr = 1'b0;
    bus.rd = 1'b1;
    @(negedge clk);
    bus.rd = 1'b0;
    chk("rdata after write", 23'h3C, 23'(rdata));
    // Past the table: write dropped, read empty
    wreg(8'h14, 8'hA5);
    rd(tvvt_pkg::TVVT_PORT_DATA, 8'h00);
    rd(8'hD4, 8'h00);
  endtask

  task automatic t_ctrl();
    logic [7:0] c;
    for (int f = 0; f < 8; f++) begin
      c = {3'(f), f[0], f[1], 1'b1, 1'b0, f[2]};
      wreg(tvvt_pkg::TVVT_IDX_CTRL, c);
      chk("filter", c[7] ? 23'h4 : 23'(c[7:5]), 23'(filter_mode));
      chk("composite_on", 23'(!c[4]), 23'(composite_on));
      chk("svideo_on", 23'(!c[3]), 23'(svideo_on));
      chk("tv_mode_on", 23'h1, 23'(tv_mode_on));
    end
    wreg(tvvt_pkg::TVVT_IDX_SCALE, 8'hA5);
    chk("compress", 23'hA5, 23'(vertical_compress_factor));
    wreg(tvvt_pkg::TVVT_IDX_STD_PH_HI, 8'h80);
    chk("pal", 23'h1, 23'(pal_select));
  endtask

  task automatic t_phase();
    logic [22:0] p;
    wreg(tvvt_pkg::TVVT_IDX_STD_PH_HI, 8'h05);
    chk("pal", 23'h0, 23'(pal_select));
    wreg(tvvt_pkg::TVVT_IDX_PH_MID, 8'h12);
    wreg(tvvt_pkg::TVVT_IDX_PH_LO, 8'h34);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h04);
    p = subcarrier_phase;
    @(negedge clk);
    chk("phase step", 23'h051234, subcarrier_phase - p);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h00);
    // Accumulator clears one edge after TV mode drops
    @(negedge clk);
    chk("phase off", 23'h0, subcarrier_phase);
  endtask

  // One field of 16 lines from the preset, windows judged line by line
  task automatic field(input logic odd, input logic [9:0] e1, vs, e2, as, ae, input logic [9:0] ns, na);
    logic [9:0] c;
    logic [2:0] w;
    pulse(1'b1);
    for (int k = 0; k < 16; k++) begin
      // Windows follow the count one edge later
      @(negedge clk);
      c = 10'h102 + 10'(k);
      w[2] = (c < e1) || (c >= vs && c < e2);
      w[1] = (c >= e1) && (c < vs);
      w[0] = (c >= e2) && (c >= as) && (c < ae);
      chk("line_count", 23'(c), 23'(line_count));
      chk("windows", 23'(w), 23'(vtim[2:0]));
      pulse(1'b0);
    end
    chk("odd_field", 23'(odd), 23'(vtim.odd_field));
    chk("sync lines", 23'(ns), 23'(sync_lines));
    chk("picture lines", 23'(na), 23'(pic_lines));
  endtask

  task automatic t_fields();
    for (int i = 0; i < 14; i++) wreg(tbl[i][15:8], tbl[i][7:0]);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h04);
    field(1'b1, 10'h105, 10'h108, 10'h10A, 10'h10C, 10'h110, 10'd3, 10'd4);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h05);
    field(1'b0, 10'h104, 10'h106, 10'h109, 10'h10B, 10'h10E, 10'd2, 10'd3);
    field(1'b1, 10'h105, 10'h108, 10'h10A, 10'h10C, 10'h110, 10'd3, 10'd4);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h00);
    pulse(1'b1);
    chk("windows off", 23'h0, 23'(vtim[2:0]));
  endtask

  // Half-scale shrink drops every other line
  task automatic t_shrink();
    int n;
    n = 0;
    wreg(tvvt_pkg::TVVT_IDX_SCALE, 8'h80);
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h06);
    for (int k = 0; k < 8; k++) begin
      pulse(1'b0);
      n += int'(line_skip === 1'b1);
    end
    chk("dropped lines", 23'd4, 23'(n));
    wreg(tvvt_pkg::TVVT_IDX_CTRL, 8'h04);
    pulse(1'b0);
    chk("line_skip", 23'h0, 23'(line_skip));
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_ctrl();
    t_phase();
    t_fields();
    t_shrink();
    end_of_test();
  end
endmodule
